// File: src/clk_stop_pkg.sv
// constants, register map and types for the clock output stop control block
package clk_stop_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_BUS_HALT_SEL = 8'h03;
	localparam logic [7:0] ADDR_HALT_EN      = 8'h04;
	localparam logic [7:0] ADDR_DRIVE_MODE   = 8'h05;
	localparam logic [7:0] ADDR_MISC_CTL     = 8'h06;
	localparam logic [7:0] ADDR_CHIP_ID      = 8'h07;
	localparam logic [7:0] ADDR_REQ_GROUP    = 8'h08;

	// reset values and writable masks
	localparam logic [7:0] RST_BUS_HALT_SEL  = 8'h00;
	localparam logic [7:0] RST_HALT_EN       = 8'h07;
	localparam logic [7:0] RST_DRIVE_MODE    = 8'h00;
	localparam logic [7:0] RST_MISC_CTL      = 8'h18;
	localparam logic [7:0] RST_REQ_GROUP     = 8'h44;
	localparam logic [7:0] MASK_HALT_EN      = 8'h5f;
	localparam logic [7:0] MASK_MISC_CTL     = 8'hd8;
	localparam logic [7:0] MASK_REQ_GROUP    = 8'h77;

	// identification fields, values arbitrary
	localparam logic [3:0] REVISION_CODE     = 4'h3;
	localparam logic [3:0] VENDOR_CODE       = 4'h5;

	// field positions
	localparam int HE_PROC_LSB      = 0;
	localparam int HE_FREE_LSB      = 3;
	localparam int HE_VIDEO_OFF_HIZ = 6;
	localparam int DM_PROC_OFF_LSB  = 0;
	localparam int DM_REF_OFF_HIZ   = 3;
	localparam int DM_PROC_STOP_LSB = 4;
	localparam int DM_REF_STOP_HIZ  = 7;
	localparam int MISC_SW_BUS_RUN  = 3;
	localparam int RG_A_LSB         = 0;
	localparam int RG_B_LSB         = 4;

	// output counts
	localparam int N_REF  = 8;
	localparam int N_GRP  = 6;
	localparam int N_PROC = 3;
	localparam int N_BUS  = 6;
	localparam int N_FREE = 2;

	// output clock half periods in system cycles, minus one
	localparam int         DIV_W     = 4;
	localparam logic [3:0] DIFF_LAST = 4'h1;
	localparam logic [3:0] BUS_LAST  = 4'h7;

	// power-up latency after power-down release
	localparam int SYS_PERIOD_NS = 4;
	localparam int UP_RESUME_NS  = 1800000;
	localparam int UP_RESUME_CYC = UP_RESUME_NS / SYS_PERIOD_NS;
	localparam int LOCK_W        = 19;

	typedef enum logic [2:0] {
		ST_WAIT_GOOD,
		ST_LOCKING,
		ST_RUN,
		ST_STOPPING,
		ST_DOWN
	} pwr_state_e;

	function automatic logic [DIV_W-1:0] div_next(input logic [DIV_W-1:0] cnt,
		input logic [DIV_W-1:0] last);
		return (cnt == last) ? '0 : cnt + 1'b1;
	endfunction

endpackage

// File: src/pin_sync3.sv
// three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic async_in,
	output logic      level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			s1_r  <= RST_VAL;
			s2_r  <= RST_VAL;
			s3_r  <= RST_VAL;
			level <= RST_VAL;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				level <= s3_r;
		end
	end
endmodule

// File: src/clock_output_stop_control.sv
// output gating and power-down sequencing for the clock generator outputs
// Notes on behaviour
// - bits 6,5,4 let request B stop reference 5,3,1; bit 6 resets set
// - bits 2,1,0 let request A stop reference 4,2,0; bit 2 resets set
// - request inputs async, accepted after equal on two complement rising edges
// - request low resumes its stopped outputs together, glitch free, in 2-6 periods
// - request high stops enabled outputs after next transition, low and undriven
// - shared pin is power good until sampled low, then power-down request
// - power-down synchronised, clocks held before oscillator and synthesizer stop
// - two complement samples high; single-ended low next fall, differential within four
// - power-down differential: mode 0 drives true high, mode 1 tristates both
// - clocks stable within 1.8 ms of release; tristated outputs driven high sooner
// - processor stop halts enabled outputs within two to six periods after sampling
// - stopped processor output holds true high, complement undriven; stop mode 1 tristates the true pin too
// - processor outputs resume within two cycles, no short or long pulses
// - bus stop low stops bus clocks; non-stoppable free bus clocks unaffected
// - bus stop release resumes bus clocks synchronously within two bus periods
// - pin low or software bit low stops stoppable bus clocks, held low
// - software bus stop bit resets set; clear stops, set resumes cleanly
// - three enables, reset set, let processor outputs obey processor stop
`timescale 1ns/1ps
module clock_output_stop_control
	import clk_stop_pkg::*;
#(
	parameter int LOCK_CYC = UP_RESUME_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_request_a_n,
	input  wire logic              clk_request_b_n,
	input  wire logic              proc_clock_halt_n,
	input  wire logic              bus_clock_halt_n,
	input  wire logic              good_or_power_down,
	input  wire logic [7:0]        reg_addr,
	input  wire logic              reg_wr_en,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	output logic      [N_REF-1:0]  ref_diff_out_t,
	output logic      [N_REF-1:0]  ref_diff_out_c,
	output logic      [N_REF-1:0]  ref_t_oe,
	output logic      [N_REF-1:0]  ref_c_oe,
	output logic      [N_PROC-1:0] proc_clk_true,
	output logic      [N_PROC-1:0] proc_clk_comp,
	output logic      [N_PROC-1:0] proc_true_oe,
	output logic      [N_PROC-1:0] proc_comp_oe,
	output logic                   video_diff_clock_t,
	output logic                   video_diff_clock_c,
	output logic                   video_t_oe,
	output logic                   video_c_oe,
	output logic      [N_BUS-1:0]  bus_clk,
	output logic      [N_FREE-1:0] free_bus_clock,
	output logic                   osc_enable
);
	logic [7:0]        bus_halt_sel_r;
	logic [7:0]        halt_en_r;
	logic [7:0]        drive_mode_r;
	logic [7:0]        misc_ctl_r;
	logic [7:0]        req_group_r;
	logic [DIV_W-1:0]  diff_cnt_r;
	logic [DIV_W-1:0]  bus_cnt_r;
	logic              diff_phase_r;
	logic              bus_phase_r;
	logic [3:0]        pin_lvl;
	logic              bus_pin_lvl;
	logic [3:0]        samp_r;
	logic [3:0]        acc_r;
	pwr_state_e        state_r;
	logic [LOCK_W-1:0] lock_cnt_r;
	logic              diff_hold_r;
	logic              se_hold_r;
	logic [N_REF-1:0]  ref_run_r;
	logic [N_PROC-1:0] proc_run_r;
	logic              bus_run_r;
	logic [N_FREE-1:0] free_run_r;
	logic              diff_tick;
	logic              diff_rise_tick;
	logic              diff_fall_tick;
	logic              bus_tick;
	logic              bus_rise_tick;
	logic              bus_fall_tick;
	logic              proc_halt;
	logic              down_seen;
	logic              bus_stop;
	logic              locking;
	logic [N_REF-1:0]  req_stop;
	logic [N_REF-1:0]  ref_want_stop;

	// request a, request b, processor halt, shared power pin
	pin_sync3 #(.RST_VAL(1'b1)) u_sync_req_a (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (clk_request_a_n),
		.level    (pin_lvl[0])
	);
	pin_sync3 #(.RST_VAL(1'b1)) u_sync_req_b (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (clk_request_b_n),
		.level    (pin_lvl[1])
	);
	pin_sync3 #(.RST_VAL(1'b1)) u_sync_proc (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (proc_clock_halt_n),
		.level    (pin_lvl[2])
	);
	pin_sync3 #(.RST_VAL(1'b1)) u_sync_pwr (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (good_or_power_down),
		.level    (pin_lvl[3])
	);
	pin_sync3 #(.RST_VAL(1'b1)) u_sync_bus (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (bus_clock_halt_n),
		.level    (bus_pin_lvl)
	);

	assign diff_tick      = (diff_cnt_r == DIFF_LAST);
	assign diff_rise_tick = diff_tick && !diff_phase_r;
	// complement rising edge is the true falling edge
	assign diff_fall_tick = diff_tick && diff_phase_r;
	assign bus_tick       = (bus_cnt_r == BUS_LAST);
	assign bus_rise_tick  = bus_tick && !bus_phase_r;
	assign bus_fall_tick  = bus_tick && bus_phase_r;
	assign proc_halt      = !acc_r[2];
	assign down_seen      = acc_r[3];
	assign locking        = (state_r == ST_LOCKING);
	assign bus_stop       = !(bus_pin_lvl && misc_ctl_r[MISC_SW_BUS_RUN]);

	always_comb
	begin
		for (int i = 0; i < N_REF; i++)
		begin
			req_stop[i] = 1'b0;
			if (i < N_GRP)
				req_stop[i] = (i % 2 == 1) ?
					(req_group_r[RG_B_LSB + i / 2] && acc_r[1]) :
					(req_group_r[RG_A_LSB + i / 2] && acc_r[0]);
			ref_want_stop[i] = req_stop[i] || (bus_stop && bus_halt_sel_r[i]);
		end
	end

	// register writes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			bus_halt_sel_r <= RST_BUS_HALT_SEL;
			halt_en_r      <= RST_HALT_EN;
			drive_mode_r   <= RST_DRIVE_MODE;
			misc_ctl_r     <= RST_MISC_CTL;
			req_group_r    <= RST_REQ_GROUP;
		end
		else if (reg_wr_en)
		begin
			unique case (reg_addr)
				ADDR_BUS_HALT_SEL: bus_halt_sel_r <= reg_wdata;
				ADDR_HALT_EN:      halt_en_r      <= reg_wdata & MASK_HALT_EN;
				ADDR_DRIVE_MODE:   drive_mode_r   <= reg_wdata;
				ADDR_MISC_CTL:     misc_ctl_r     <= reg_wdata & MASK_MISC_CTL;
				ADDR_REQ_GROUP:    req_group_r    <= reg_wdata & MASK_REQ_GROUP;
				default:           ;
			endcase
		end
	end

	// register reads; identification ignores writes
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
		begin
			unique case (reg_addr)
				ADDR_BUS_HALT_SEL: reg_rdata <= bus_halt_sel_r;
				ADDR_HALT_EN:      reg_rdata <= halt_en_r;
				ADDR_DRIVE_MODE:   reg_rdata <= drive_mode_r;
				ADDR_MISC_CTL:     reg_rdata <= misc_ctl_r;
				ADDR_CHIP_ID:      reg_rdata <= {REVISION_CODE, VENDOR_CODE};
				ADDR_REQ_GROUP:    reg_rdata <= req_group_r;
				default:           reg_rdata <= 8'h00;
			endcase
		end
	end

	// output clock phases
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			diff_cnt_r   <= '0;
			bus_cnt_r    <= '0;
			diff_phase_r <= 1'b0;
			bus_phase_r  <= 1'b0;
		end
		else
		begin
			diff_cnt_r <= div_next(diff_cnt_r, DIFF_LAST);
			bus_cnt_r  <= div_next(bus_cnt_r, BUS_LAST);
			if (diff_tick)
				diff_phase_r <= !diff_phase_r;
			if (bus_tick)
				bus_phase_r <= !bus_phase_r;
		end
	end

	// debounce on complement rising edges: a level must match two samples running
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			samp_r <= 4'hf;
			acc_r  <= 4'hf;
		end
		else if (diff_fall_tick)
		begin
			samp_r <= pin_lvl;
			for (int k = 0; k < 4; k++)
				if (pin_lvl[k] == samp_r[k])
					acc_r[k] <= pin_lvl[k];
		end
	end

	// power sequencing
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_r    <= ST_WAIT_GOOD;
			lock_cnt_r <= '0;
		end
		else
		begin
			unique case (state_r)
				ST_WAIT_GOOD:
					if (!down_seen)
						state_r <= ST_LOCKING;
				ST_LOCKING:
					if (down_seen)
						state_r <= ST_DOWN;
					else if (lock_cnt_r == LOCK_W'(LOCK_CYC - 1))
						state_r <= ST_RUN;
				ST_RUN:
					if (down_seen)
						state_r <= ST_STOPPING;
				ST_STOPPING:
					if (diff_hold_r && se_hold_r)
						state_r <= ST_DOWN;
				ST_DOWN:
					if (!down_seen)
						state_r <= ST_LOCKING;
			endcase
			lock_cnt_r <= locking ? lock_cnt_r + 1'b1 : '0;
		end
	end

	// oscillator only runs once good and outside power-down
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			osc_enable <= 1'b0;
		else
			osc_enable <= (state_r != ST_DOWN) && (state_r != ST_WAIT_GOOD);
	end

	// power-down holds: differential on complement fall, single-ended on falling edge
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			diff_hold_r <= 1'b1;
			se_hold_r   <= 1'b1;
		end
		else
		begin
			if (state_r == ST_STOPPING && diff_rise_tick)
				diff_hold_r <= 1'b1;
			else if (state_r == ST_RUN && diff_fall_tick)
				diff_hold_r <= 1'b0;
			if (state_r == ST_STOPPING && bus_fall_tick)
				se_hold_r <= 1'b1;
			else if (state_r == ST_RUN && bus_rise_tick)
				se_hold_r <= 1'b0;
		end
	end

	// gate changes only at edges so no short pulse can escape
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ref_run_r  <= '1;
			proc_run_r <= '1;
			bus_run_r  <= 1'b1;
			free_run_r <= '1;
		end
		else
		begin
			for (int i = 0; i < N_REF; i++)
				if (diff_fall_tick && ref_want_stop[i])
					ref_run_r[i] <= 1'b0;
				else if (diff_rise_tick && !ref_want_stop[i])
					ref_run_r[i] <= 1'b1;
			for (int i = 0; i < N_PROC; i++)
				if (diff_rise_tick && proc_halt && halt_en_r[HE_PROC_LSB + i])
					proc_run_r[i] <= 1'b0;
				else if (diff_fall_tick && !(proc_halt && halt_en_r[HE_PROC_LSB + i]))
					proc_run_r[i] <= 1'b1;
			if (bus_fall_tick && bus_stop)
				bus_run_r <= 1'b0;
			else if (bus_rise_tick && !bus_stop)
				bus_run_r <= 1'b1;
			for (int j = 0; j < N_FREE; j++)
				if (bus_fall_tick && bus_stop && halt_en_r[HE_FREE_LSB + j])
					free_run_r[j] <= 1'b0;
				else if (bus_rise_tick && !(bus_stop && halt_en_r[HE_FREE_LSB + j]))
					free_run_r[j] <= 1'b1;
		end
	end

	// differential pins; while locking the true pin is driven high
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			ref_diff_out_t     <= '0;
			ref_diff_out_c     <= '0;
			ref_t_oe           <= '0;
			ref_c_oe           <= '0;
			proc_clk_true      <= '0;
			proc_clk_comp      <= '0;
			proc_true_oe       <= '0;
			proc_comp_oe       <= '0;
			video_diff_clock_t <= 1'b0;
			video_diff_clock_c <= 1'b0;
			video_t_oe         <= 1'b0;
			video_c_oe         <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < N_REF; i++)
			begin
				ref_c_oe[i] <= !diff_hold_r && ref_run_r[i];
				if (diff_hold_r)
				begin
					ref_diff_out_t[i] <= 1'b1;
					ref_diff_out_c[i] <= 1'b0;
					ref_t_oe[i]       <= locking || !drive_mode_r[DM_REF_OFF_HIZ];
				end
				else if (!ref_run_r[i])
				begin
					ref_diff_out_t[i] <= 1'b0;
					ref_diff_out_c[i] <= 1'b0;
					ref_t_oe[i]       <= !req_stop[i] && !drive_mode_r[DM_REF_STOP_HIZ];
					ref_c_oe[i]       <= !req_stop[i] && !drive_mode_r[DM_REF_STOP_HIZ];
				end
				else
				begin
					ref_diff_out_t[i] <= diff_phase_r;
					ref_diff_out_c[i] <= !diff_phase_r;
					ref_t_oe[i]       <= 1'b1;
				end
			end
			for (int i = 0; i < N_PROC; i++)
			begin
				proc_comp_oe[i]  <= !diff_hold_r && proc_run_r[i];
				proc_clk_comp[i] <= !diff_hold_r && proc_run_r[i] && !diff_phase_r;
				if (diff_hold_r)
				begin
					proc_clk_true[i] <= 1'b1;
					proc_true_oe[i]  <= locking || !drive_mode_r[DM_PROC_OFF_LSB + i];
				end
				else
				begin
					proc_clk_true[i] <= !proc_run_r[i] || diff_phase_r;
					proc_true_oe[i]  <= proc_run_r[i] || !drive_mode_r[DM_PROC_STOP_LSB + i];
				end
			end
			video_diff_clock_t <= diff_hold_r || diff_phase_r;
			video_diff_clock_c <= !diff_hold_r && !diff_phase_r;
			video_t_oe         <= !diff_hold_r || locking || !halt_en_r[HE_VIDEO_OFF_HIZ];
			video_c_oe         <= !diff_hold_r;
		end
	end

	// single-ended bus clocks, held low when stopped or powered down
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			bus_clk        <= '0;
			free_bus_clock <= '0;
		end
		else
		begin
			bus_clk        <= {N_BUS{!se_hold_r && bus_run_r && bus_phase_r}};
			free_bus_clock <= {N_FREE{!se_hold_r && bus_phase_r}} & free_run_r;
		end
	end

	chk_ref_resume_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(|(ref_run_r & ~$past(ref_run_r))) |-> diff_phase_r)
		else $error("reference output resumed away from a rising edge");

	chk_ref_stop_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((|(~ref_run_r & $past(ref_run_r))) && !diff_hold_r) |->
			!diff_phase_r ##1 (ref_diff_out_t == (ref_diff_out_t & ref_run_r)))
		else $error("reference output stopped away from a falling edge");

	chk_req_debounce_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(acc_r[1:0] != $past(acc_r[1:0])) |-> $past(diff_fall_tick) &&
			(((acc_r[1:0] ^ $past(acc_r[1:0])) & (acc_r[1:0] ^ $past(samp_r[1:0]))) == 2'b00) &&
			(((acc_r[1:0] ^ $past(acc_r[1:0])) & (acc_r[1:0] ^ samp_r[1:0])) == 2'b00))
		else $error("request level accepted without two matching samples");

	chk_proc_stop_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!diff_hold_r && !proc_run_r[0]) |=> proc_clk_true[0] && !proc_comp_oe[0])
		else $error("stopped processor output not held high with complement released");

	chk_proc_resume_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(proc_run_r[0]) |-> !diff_phase_r && $past(!(proc_halt && halt_en_r[HE_PROC_LSB])))
		else $error("processor output resumed on the wrong edge");

	chk_bus_sw_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(bus_fall_tick && !misc_ctl_r[MISC_SW_BUS_RUN]) |=> !bus_run_r ##1 bus_clk == '0)
		else $error("software bus stop did not hold bus clocks low");

	chk_free_keep_run: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(free_run_r[0]) |-> $past(halt_en_r[HE_FREE_LSB]) && $past(bus_fall_tick))
		else $error("non-stoppable free bus clock was stopped");

	chk_down_enter_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_r == ST_RUN ##1 state_r == ST_STOPPING) |-> ##[0:20] (state_r == ST_DOWN))
		else $error("power-down hold not reached in time");

	chk_osc_after_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_r == ST_DOWN) |-> diff_hold_r && se_hold_r ##1 !osc_enable)
		else $error("oscillator still enabled or clocks not held in power-down");

	chk_down_drive_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(diff_hold_r && !locking && drive_mode_r[DM_PROC_OFF_LSB]) |=>
			!proc_true_oe[0] && !proc_comp_oe[0])
		else $error("tristate power-down mode still drives a processor pin");

endmodule

// File: test/chipset_pin_model.sv
// chipset-side model that drives the request, stop and power pins
`timescale 1ns/1ps
module chipset_pin_model (
	input  wire logic sys_clk,
	output logic      clk_request_a_n,
	output logic      clk_request_b_n,
	output logic      proc_clock_halt_n,
	output logic      bus_clock_halt_n,
	output logic      good_or_power_down
);
	// requests asserted, halts released, supply not yet good
	logic [4:0] pins_r = 5'b11100;

	assign clk_request_a_n    = pins_r[0];
	assign clk_request_b_n    = pins_r[1];
	assign proc_clock_halt_n  = pins_r[2];
	assign bus_clock_halt_n   = pins_r[3];
	// power good is never followed at once by power-down, so the part starts up
	assign good_or_power_down = pins_r[4];

	// each level is held well past two complement ticks so it is accepted
	// random hold gives the device prompt and slow partners alike
	task automatic drive(input int idx, input logic val);
		int hold;
		hold = 12 + $urandom_range(8, 0);
		@(posedge sys_clk);
		pins_r[idx] <= val;
		repeat (hold) @(posedge sys_clk);
	endtask

	// deliberate two-cycle pulse, too short to be accepted
	task automatic glitch(input int idx);
		@(posedge sys_clk);
		pins_r[idx] <= ~pins_r[idx];
		repeat (2) @(posedge sys_clk);
		pins_r[idx] <= ~pins_r[idx];
		repeat (12) @(posedge sys_clk);
	endtask
endmodule

// File: test/clock_output_stop_control_test.sv
// self-checking testbench for the clock output stop control block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module clock_output_stop_control_test;
	import clk_stop_pkg::*;
	localparam int LOCK_SIM = 40;
	localparam logic [7:0] RA[8] = '{ADDR_BUS_HALT_SEL, ADDR_HALT_EN, ADDR_DRIVE_MODE,
		ADDR_MISC_CTL, ADDR_CHIP_ID, ADDR_REQ_GROUP, 8'h09, 8'h02};
	localparam logic [7:0] RV[8] = '{RST_BUS_HALT_SEL, RST_HALT_EN, RST_DRIVE_MODE,
		RST_MISC_CTL, {REVISION_CODE, VENDOR_CODE}, RST_REQ_GROUP, 8'h00, 8'h00};
	logic              sys_clk;
	logic              rst_n;
	logic              req_a_n, req_b_n, proc_halt_n, bus_halt_n, pwr_pin;
	logic [7:0]        reg_addr, reg_wdata, reg_rdata;
	logic              reg_wr_en;
	logic [N_REF-1:0]  ref_diff_out_t, ref_diff_out_c, ref_t_oe, ref_c_oe;
	logic [N_PROC-1:0] proc_clk_true, proc_clk_comp, proc_true_oe, proc_comp_oe;
	logic              vid_t, vid_c, vid_t_oe, vid_c_oe, osc_enable;
	logic [N_BUS-1:0]  bus_clk;
	logic [N_FREE-1:0] free_bus_clock;
	logic [18:0]       outs, chg;
	logic [7:0]        exp_q[$];
	logic [7:0]        g, stop_m, exp_v;
	logic              rd_tag = 1'b0;
	logic              rd_seen = 1'b0;
	logic              hiz;
	int                num_errors = 0;
	int                check_count = 0;

	assign outs = {ref_diff_out_t, proc_clk_true, bus_clk, free_bus_clock};

	chipset_pin_model chipset_pin_model_inst (.sys_clk(sys_clk), .clk_request_a_n(req_a_n),
		.clk_request_b_n(req_b_n), .proc_clock_halt_n(proc_halt_n),
		.bus_clock_halt_n(bus_halt_n), .good_or_power_down(pwr_pin));

	clock_output_stop_control #(.LOCK_CYC(LOCK_SIM)) clock_output_stop_control_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_request_a_n(req_a_n),
		.clk_request_b_n(req_b_n), .proc_clock_halt_n(proc_halt_n),
		.bus_clock_halt_n(bus_halt_n), .good_or_power_down(pwr_pin),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .ref_diff_out_t(ref_diff_out_t),
		.ref_diff_out_c(ref_diff_out_c), .ref_t_oe(ref_t_oe), .ref_c_oe(ref_c_oe),
		.proc_clk_true(proc_clk_true), .proc_clk_comp(proc_clk_comp),
		.proc_true_oe(proc_true_oe), .proc_comp_oe(proc_comp_oe),
		.video_diff_clock_t(vid_t), .video_diff_clock_c(vid_c), .video_t_oe(vid_t_oe),
		.video_c_oe(vid_c_oe), .bus_clk(bus_clk), .free_bus_clock(free_bus_clock),
		.osc_enable(osc_enable));

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// read data lands one edge after the address, so compare one edge after that
	always @(posedge sys_clk)
	begin
		rd_seen <= rd_tag;
		if (rd_seen && exp_q.size() > 0)
		begin
			exp_v = exp_q.pop_front();
			`CHK(reg_rdata, exp_v)
		end
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		rd_tag <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		rd_tag <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// marks every true reference, processor and bus clock output that changed at least once over n cycles
	task automatic activity(input int n);
		logic [18:0] prev;
		chg = '0;
		prev = outs;
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			chg = chg | (prev ^ outs);
			prev = outs;
		end
	endtask

	initial
	begin
		repeat (30000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end

	initial
	begin
		void'($urandom(70169));
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr_en = 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		idle(2);
		`CHK(osc_enable, 1'b0)
		`CHK(bus_clk, 6'h00)
		foreach (RA[i])
			rd(RA[i], RV[i]);
		wr(ADDR_CHIP_ID, 8'($urandom));
		rd(ADDR_CHIP_ID, {REVISION_CODE, VENDOR_CODE});
		g = 8'($urandom) | 8'h11;
		wr(ADDR_REQ_GROUP, g);
		g = g & MASK_REQ_GROUP;
		rd(ADDR_REQ_GROUP, g);
		for (int i = 0; i < 8; i++)
			stop_m[i] = (i > 5) ? 1'b0 : ((i % 2) ? g[4 + i / 2] : g[i / 2]);
		// supply good, then lock and run
		chipset_pin_model_inst.drive(4, 1'b0);
		idle(LOCK_SIM + 60);
		`CHK(osc_enable, 1'b1)
		activity(32);
		`CHK(chg, {19{1'b1}})
		// short pulse on a request pin must change nothing
		chipset_pin_model_inst.glitch(0);
		chipset_pin_model_inst.glitch(1);
		`CHK(ref_t_oe, 8'hff)
		chipset_pin_model_inst.drive(0, 1'b1);
		chipset_pin_model_inst.drive(1, 1'b1);
		idle(40);
		`CHK(ref_t_oe, ~stop_m)
		`CHK(ref_c_oe, ~stop_m)
		`CHK(ref_diff_out_t & stop_m, 8'h00)
		activity(16);
		`CHK(chg[18:11], ~stop_m)
		chipset_pin_model_inst.drive(0, 1'b0);
		chipset_pin_model_inst.drive(1, 1'b0);
		idle(40);
		`CHK(ref_t_oe, 8'hff)
		repeat (8)
		begin
			idle(1);
			`CHK(((ref_diff_out_t & stop_m) == 8'h00) || ((ref_diff_out_t & stop_m) == stop_m), 1'b1)
		end
		wr(ADDR_HALT_EN, 8'h05);
		wr(ADDR_DRIVE_MODE, 8'h40);
		chipset_pin_model_inst.drive(2, 1'b0);
		idle(40);
		activity(16);
		`CHK(chg[10:8], 3'b010)
		`CHK(proc_clk_true[0], 1'b1)
		`CHK(proc_true_oe, 3'b011)
		`CHK(proc_comp_oe[0], 1'b0)
		chipset_pin_model_inst.drive(2, 1'b1);
		idle(8);
		activity(16);
		`CHK(chg[10:8], 3'b111)
		chipset_pin_model_inst.drive(3, 1'b0);
		idle(40);
		activity(32);
		`CHK(chg[7:0], 8'h03)
		`CHK(bus_clk, 6'h00)
		chipset_pin_model_inst.drive(3, 1'b1);
		idle(40);
		activity(32);
		`CHK(chg[7:0], 8'hff)
		wr(ADDR_BUS_HALT_SEL, 8'h80);
		wr(ADDR_HALT_EN, 8'h0d);
		wr(ADDR_MISC_CTL, RST_MISC_CTL & 8'hf7);
		wr(ADDR_DRIVE_MODE, 8'h80);
		idle(40);
		activity(32);
		`CHK(chg, {8'h7f, 3'b111, 6'h00, 2'b10})
		`CHK(ref_diff_out_t[7], 1'b0)
		`CHK(free_bus_clock[0], 1'b0)
		`CHK({ref_t_oe[7], ref_c_oe[7]}, 2'b00)
		wr(ADDR_MISC_CTL, RST_MISC_CTL);
		idle(40);
		activity(32);
		`CHK(chg, {19{1'b1}})
		for (int m = 0; m < 2; m++)
		begin
			hiz = m[0];
			wr(ADDR_DRIVE_MODE, hiz ? 8'h09 : 8'h00);
			wr(ADDR_HALT_EN, hiz ? 8'h4d : 8'h0d);
			chipset_pin_model_inst.drive(4, 1'b1);
			idle(50);
			`CHK(osc_enable, 1'b0)
			`CHK(ref_t_oe, {8{~hiz}})
			`CHK(ref_c_oe, 8'h00)
			`CHK(proc_true_oe, {2'b11, ~hiz})
			`CHK({proc_comp_oe, ref_diff_out_c, proc_clk_comp}, 14'h0000)
			`CHK({vid_t, vid_c, vid_t_oe, vid_c_oe}, {2'b10, ~hiz, 1'b0})
			`CHK(bus_clk, 6'h00)
			activity(32);
			`CHK(chg, 19'h00000)
			chipset_pin_model_inst.drive(4, 1'b0);
			idle(12);
			`CHK(ref_t_oe, 8'hff)
			`CHK(ref_diff_out_t, 8'hff)
			idle(LOCK_SIM + 60);
			`CHK(osc_enable, 1'b1)
			activity(32);
			`CHK(chg, {19{1'b1}})
			`CHK({ref_diff_out_c, proc_clk_comp, vid_c}, ~{ref_diff_out_t, proc_clk_true, vid_t})
			`CHK({vid_t_oe, vid_c_oe}, 2'b11)
		end
		complete_run();
	end
endmodule
